// [src/dbsp_pkg.sv]
// Shared constants for the burst-of-two DDR SRAM port: widths, variant,
// calibration and controller timing.
// Assumes both ends and the carrier import it whole.
`default_nettype none
package dbsp_pkg;
   // ========================================
   // Widths of the 18-bit-wide variant
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 2;
   localparam int WORD_W = 2 * DATA_W;
   localparam int WLANES = 2 * LANES;
   localparam int ADDR_W = 8;
   localparam int ROW_W = ADDR_W - 1;
   localparam int MEM_DEPTH = 128;
   // Wide variants steer burst order from the lowest address bit
   localparam logic WIDE_VARIANT = 1'b1;
   // ========================================
   // Output impedance calibration
   localparam int ZQ_CODE_W = 6;
   localparam logic [5:0] ZQ_CODE_MIN_Z = 6'h3f;
   localparam logic [5:0] ZQ_CODE_RESET = 6'h20;
   localparam logic [5:0] ZQ_CODE_ZERO = 6'h00;
   localparam int ZQ_PERIOD_DEFAULT = 1024;
   localparam int ZQ_CNT_W = 12;
   // ========================================
   // Bit positions in the device input synchroniser
   localparam int SY_RST = 0;
   localparam int SY_CTIE = 1;
   localparam int SY_ZREF = 2;
   localparam int SY_UP = 3;
   localparam int SY_DN = 4;
   localparam int SY_DLL = 5;
   localparam int SYNC_W = 6;
   // ========================================
   // Controller timing: link clock divided from the 8 ns system clock
   localparam int CLK_PERIOD_NS = 8;
   localparam int K_PERIOD_NS = 32;
   localparam int K_DIV = K_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] PH_LAST = 2'(K_DIV - 1);
   localparam logic [1:0] PH_HALF = 2'(K_DIV / 2);
   localparam logic [1:0] PH_TAKE = 2'h2;
   // Pipeline taps, in system clocks after a command is put on the pins
   localparam int PIPE_LEN = 13;
   localparam int WR_D1_TAP = 3;
   localparam int WR_D2_TAP = 5;
   localparam int WR_END_TAP = 7;
   localparam int RD_B1_TAP = 10;
   localparam int RD_B2_TAP = 12;
endpackage
`default_nettype wire

// [src/dbsp_if.sv]
// Pin bundle between the memory controller and the SRAM device.
// Assumes the controller makes both clock pairs; the shared data bus
// level is resolved here from the two output enables.
`default_nettype none
interface dbsp_if;
   import dbsp_pkg::*;
   // ========================================
   // Clocks: falling edges stand for the complementary clocks
   logic kClk;
   logic cClk;
   // Command pins
   logic loadN;
   logic rwRead;
   logic [ADDR_W-1:0] syncAddressIn;
   logic [LANES-1:0] byteWriteMaskN;
   // Data bus halves and their enables
   logic [DATA_W-1:0] hostDq;
   logic hostOe;
   logic [DATA_W-1:0] devDq;
   logic devOe;
   logic echoStrobeOut;
   wire logic [DATA_W-1:0] dq;
   // Device wins only while it drives; an idle bus reads as its pull-up level
   assign dq = devOe ? devDq : (hostOe ? hostDq : '1);
   modport device (
      input kClk, cClk, loadN, rwRead, syncAddressIn, byteWriteMaskN, dq,
      output devDq, devOe, echoStrobeOut
   );
   modport host (
      input dq, echoStrobeOut,
      output kClk, cClk, loadN, rwRead, syncAddressIn, byteWriteMaskN,
      output hostDq, hostOe
   );
endinterface
`default_nettype wire

// [src/dbsp_device.sv]
// SRAM device end: late-write burst-of-two store, pipelined read,
// deselect pipeline and output impedance calibration.
// Assumes every link pin is source-synchronous to the link clock pair and
// that the controller keeps the bus turnaround gap itself.
//
// How it works
// - Address, load and read select sampled together
// - Each command moves exactly two data beats
// - Controller may issue every cycle or idle
// - First read beat on output falling edge
// - Second read beat on next output rise
// - First write beat one edge after command
// - Second write beat on next falling edge
// - Deselect pipelined like reads, then float bus
// - Load high ignores commands, bursts finish
// - Masks sampled with their data beats
// - Masked lane keeps its stored contents
// - Any mask pattern allowed per beat
// - Each address holds a two-beat word
// - Narrow variant masks per nybble lane
// - Output clocks fire outputs, else input clocks
// - Cycle counter triggers periodic impedance evaluation
// - One binary step per evaluation
// - Reference at supply selects minimum impedance
// - Loop-disable low turns delay loop off
// - Narrow variants force lowest address bit zero
`default_nettype none
module dbsp_device #(
   parameter int ZQ_PERIOD = dbsp_pkg::ZQ_PERIOD_DEFAULT
) (
   dbsp_if.device bus,
   input wire logic srst,
   input wire logic cTiedHigh,
   input wire logic impedanceRefPinAtVddq,
   input wire logic impedanceRaise,
   input wire logic impedanceLower,
   input wire logic dllOffN,
   output logic [dbsp_pkg::ZQ_CODE_W-1:0] impedanceCode,
   output logic dllEnabled
);
   import dbsp_pkg::*;

   // ========================================
   // Helper functions

   // Put the beat bound for the lower half first or second
   function automatic logic [WORD_W-1:0] orderWord(
      input logic [WORD_W-1:0] w,
      input logic half
   );
      orderWord = half ? {w[DATA_W-1:0], w[WORD_W-1:DATA_W]} : w;
   endfunction

   // Same ordering for the per-lane masks
   function automatic logic [WLANES-1:0] orderMask(
      input logic [WLANES-1:0] m,
      input logic half
   );
      orderMask = half ? {m[LANES-1:0], m[WLANES-1:LANES]} : m;
   endfunction

   // Merge new lanes into a stored word; a high mask keeps the old lane
   function automatic logic [WORD_W-1:0] mergeLanes(
      input logic [WORD_W-1:0] oldW,
      input logic [WORD_W-1:0] newW,
      input logic [WLANES-1:0] maskN
   );
      mergeLanes = oldW;
      for (int i = 0; i < WLANES; i++) begin
         if (!maskN[i]) begin
            mergeLanes[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
         end
      end
   endfunction

   // ========================================
   // Side-input synchroniser on the link clock

   // Two stages; only the second stage is read by logic
   logic [SYNC_W-1:0] syncA_reg;
   logic [SYNC_W-1:0] syncB_reg;

   always_ff @(posedge bus.kClk) begin
      syncA_reg <= {dllOffN, impedanceLower, impedanceRaise,
                    impedanceRefPinAtVddq, cTiedHigh, srst};
      syncB_reg <= syncA_reg;
   end

   // Reset seen in the link domain
   wire logic rstK = syncB_reg[SY_RST];

   // Output register clock: tie strap falls back to the input clock
   // Limitation: the strap is a static choice, not a live clock switch
   wire logic oClk = syncB_reg[SY_CTIE] ? bus.kClk : bus.cClk;

   // ========================================
   // Command decode on the input clock rising edge

   // Load high is a deselect; the read select is then ignored
   wire logic loadTaken = !bus.loadN;
   wire logic rdCmd = loadTaken && bus.rwRead;
   wire logic wrCmd = loadTaken && !bus.rwRead;
   // Lowest bit is forced low where the variant has no such pin
   wire logic firstHalf = WIDE_VARIANT ? bus.syncAddressIn[0] : 1'b0;
   wire logic [ROW_W-1:0] cmdRow = bus.syncAddressIn[ADDR_W-1:1];

   // ========================================
   // Storage: one double-width word per address

   logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];

   // ========================================
   // Pipeline state

   logic rdIssue_reg; // Read captured, array read due next edge
   logic [ROW_W-1:0] rdRow_reg;
   logic rdHalf_reg;
   logic rdLive_reg; // Word ready for the output stage
   logic [WORD_W-1:0] rdWord_reg; // First beat in the low half
   logic wrIssue_reg; // Write captured, first beat due next edge
   logic [ROW_W-1:0] wrRow_reg;
   logic wrHalf_reg;
   logic wrCommit_reg; // Both beats in, array update due
   logic [ROW_W-1:0] cRow_reg;
   logic cHalf_reg;
   logic [DATA_W-1:0] beat1_reg;
   logic [LANES-1:0] mask1_reg;
   logic [DATA_W-1:0] beat2_reg;
   logic [LANES-1:0] mask2_reg;

   // Assembled write word and masks in array order
   wire logic [WORD_W-1:0] wrWord = orderWord({beat2_reg, beat1_reg}, cHalf_reg);
   wire logic [WLANES-1:0] wrMaskN = orderMask({mask2_reg, mask1_reg}, cHalf_reg);

   // Control pipeline: reads and deselects share one latency
   always_ff @(posedge bus.kClk) begin
      if (rstK) begin
         rdIssue_reg <= 1'b0;
         rdLive_reg <= 1'b0;
         wrIssue_reg <= 1'b0;
         wrCommit_reg <= 1'b0;
      end else begin
         rdIssue_reg <= rdCmd;
         rdLive_reg <= rdIssue_reg;
         wrIssue_reg <= wrCmd;
         wrCommit_reg <= wrIssue_reg;
      end
   end

   // Address and data capture; no reset needed on pure data
   always_ff @(posedge bus.kClk) begin
      rdRow_reg <= cmdRow;
      rdHalf_reg <= firstHalf;
      wrRow_reg <= cmdRow;
      wrHalf_reg <= firstHalf;
      // Critical half first on the way out
      rdWord_reg <= orderWord(mem[rdRow_reg], rdHalf_reg);
      // Late write: first beat and its mask one edge after the command
      beat1_reg <= bus.dq;
      mask1_reg <= bus.byteWriteMaskN;
      cRow_reg <= wrRow_reg;
      cHalf_reg <= wrHalf_reg;
   end

   // Second write beat on the complementary clock rise
   always_ff @(negedge bus.kClk) begin
      beat2_reg <= bus.dq;
      mask2_reg <= bus.byteWriteMaskN;
   end

   // Array update once both beats are in
   // Trade-off: a read of the same row on this edge sees the old word
   always_ff @(posedge bus.kClk) begin
      if (wrCommit_reg && !rstK) begin
         mem[cRow_reg] <= mergeLanes(mem[cRow_reg], wrWord, wrMaskN);
      end
   end

   // ========================================
   // Output stage on the output register clock

   logic [WORD_W-1:0] outWord_reg;
   logic devOe_reg;

   // Falling edge launches a burst or floats the bus after the last one
   always_ff @(negedge oClk) begin
      if (rstK) begin
         devOe_reg <= 1'b0;
      end else begin
         devOe_reg <= rdLive_reg;
      end
      outWord_reg <= rdWord_reg;
   end

   // DDR mux: first beat while low, second after the next rise
   assign bus.devDq = oClk ? outWord_reg[WORD_W-1:DATA_W] : outWord_reg[DATA_W-1:0];
   assign bus.devOe = devOe_reg;
   // Echo strobe follows the clock that fires the outputs
   assign bus.echoStrobeOut = oClk;

   // ========================================
   // Output impedance calibration

   logic [ZQ_CNT_W-1:0] zqCnt_reg;
   logic [ZQ_CODE_W-1:0] zqCode_reg;
   logic dllEnabled_reg;

   wire logic zqDue = zqCnt_reg == ZQ_CNT_W'(ZQ_PERIOD - 1);
   wire logic zqAtMax = zqCode_reg == ZQ_CODE_MIN_Z;
   wire logic zqAtMin = zqCode_reg == ZQ_CODE_ZERO;

   // Counter wraps after each evaluation; one step at most per pass
   always_ff @(posedge bus.kClk) begin
      if (rstK) begin
         zqCnt_reg <= '0;
         zqCode_reg <= ZQ_CODE_RESET;
      end else begin
         zqCnt_reg <= zqDue ? '0 : zqCnt_reg + 1'b1;
         if (syncB_reg[SY_ZREF]) begin
            // Reference at output supply: strongest drive, no tracking
            zqCode_reg <= ZQ_CODE_MIN_Z;
         end else if (zqDue && syncB_reg[SY_UP] && !zqAtMax) begin
            zqCode_reg <= zqCode_reg + 1'b1;
         end else if (zqDue && syncB_reg[SY_DN] && !syncB_reg[SY_UP] && !zqAtMin) begin
            zqCode_reg <= zqCode_reg - 1'b1;
         end
      end
   end

   // Delay loop runs only while the disable pin is released
   always_ff @(posedge bus.kClk) begin
      if (rstK) begin
         dllEnabled_reg <= 1'b0;
      end else begin
         dllEnabled_reg <= syncB_reg[SY_DLL];
      end
   end

   assign impedanceCode = zqCode_reg;
   assign dllEnabled = dllEnabled_reg;

endmodule
`default_nettype wire

// [src/dbsp_host.sv]
// Memory controller end: makes both clock pairs from clk, issues one
// command per link cycle, drives late-write beats and collects reads.
// Assumes the device output clock is used, lagging the input clock by
// one system clock as driven here.
`default_nettype none
module dbsp_host (
   input wire logic clk,
   input wire logic srst,
   dbsp_if.host bus,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdRead,
   input wire logic [dbsp_pkg::ADDR_W-1:0] cmdAddr,
   input wire logic [dbsp_pkg::WORD_W-1:0] cmdWrData,
   input wire logic [dbsp_pkg::WLANES-1:0] cmdWrMaskN,
   output logic rdValid,
   output logic [dbsp_pkg::WORD_W-1:0] rdData
);
   import dbsp_pkg::*;

   // ========================================
   // Clock divider: link clock high for the first half of each phase
   logic [1:0] ph_reg;
   logic kClk_reg;
   logic cClk_reg;
   wire logic [1:0] phNext = (ph_reg == PH_LAST) ? 2'h0 : ph_reg + 2'h1;

   always_ff @(posedge clk) begin
      ph_reg <= srst ? PH_LAST : phNext;
      kClk_reg <= srst ? 1'b0 : (phNext < PH_HALF);
      cClk_reg <= kClk_reg; // Output clock lags by one system clock
   end

   // ========================================
   // Command slot: pins change one system clock before the rise
   logic prevValid_reg;
   logic prevRead_reg;
   // A write straight after a read would collide on the bus
   wire logic turnBlock = prevValid_reg && prevRead_reg && !cmdRead;
   assign cmdReady = !srst && (ph_reg == PH_TAKE) && !turnBlock;
   wire logic take = cmdValid && cmdReady;
   wire logic slot = ph_reg == PH_TAKE;

   logic loadN_reg;
   logic rwRead_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [PIPE_LEN-1:0] wrPipe_reg;
   logic [PIPE_LEN-1:0] rdPipe_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         loadN_reg <= 1'b1;
         rwRead_reg <= 1'b1;
         prevValid_reg <= 1'b0;
         prevRead_reg <= 1'b0;
         wrPipe_reg <= '0;
         rdPipe_reg <= '0;
      end else begin
         if (slot) begin
            loadN_reg <= !take;
            rwRead_reg <= take ? cmdRead : rwRead_reg;
            prevValid_reg <= take;
            prevRead_reg <= take && cmdRead;
         end
         wrPipe_reg <= {wrPipe_reg[PIPE_LEN-2:0], take && !cmdRead};
         rdPipe_reg <= {rdPipe_reg[PIPE_LEN-2:0], take && cmdRead};
      end
      if (take) begin
         addr_reg <= cmdAddr;
      end
   end

   // ========================================
   // Write beats: first before the next rise, second before the fall
   logic [WORD_W-1:0] hold1_reg;
   logic [WLANES-1:0] hold1Mask_reg;
   logic [WORD_W-1:0] hold2_reg;
   logic [WLANES-1:0] hold2Mask_reg;
   logic [DATA_W-1:0] hostDq_reg;
   logic [LANES-1:0] mask_reg;
   logic hostOe_reg;

   always_ff @(posedge clk) begin
      if (take) begin
         hold1_reg <= cmdWrData;
         hold1Mask_reg <= cmdWrMaskN;
      end
      if (srst) begin
         hostOe_reg <= 1'b0;
         mask_reg <= '1;
         hostDq_reg <= '0;
      end else if (wrPipe_reg[WR_D1_TAP]) begin
         hostDq_reg <= hold1_reg[DATA_W-1:0];
         mask_reg <= hold1Mask_reg[LANES-1:0];
         hostOe_reg <= 1'b1;
         hold2_reg <= hold1_reg;
         hold2Mask_reg <= hold1Mask_reg;
      end else if (wrPipe_reg[WR_D2_TAP]) begin
         hostDq_reg <= hold2_reg[WORD_W-1:DATA_W];
         mask_reg <= hold2Mask_reg[WLANES-1:LANES];
      end else if (wrPipe_reg[WR_END_TAP]) begin
         hostOe_reg <= 1'b0;
         mask_reg <= '1;
      end
   end

   // ========================================
   // Read capture through two stages, beats in arrival order
   logic [DATA_W-1:0] dqA_reg;
   logic [DATA_W-1:0] dqB_reg;
   logic [DATA_W-1:0] rdLo_reg;
   logic [WORD_W-1:0] rdData_reg;
   logic rdValid_reg;

   always_ff @(posedge clk) begin
      dqA_reg <= bus.dq;
      dqB_reg <= dqA_reg;
      if (rdPipe_reg[RD_B1_TAP]) begin
         rdLo_reg <= dqB_reg;
      end
      if (srst) begin
         rdValid_reg <= 1'b0;
         rdData_reg <= '0;
      end else begin
         rdValid_reg <= rdPipe_reg[RD_B2_TAP];
         if (rdPipe_reg[RD_B2_TAP]) begin
            rdData_reg <= {dqB_reg, rdLo_reg};
         end
      end
   end

   assign bus.kClk = kClk_reg;
   assign bus.cClk = cClk_reg;
   assign bus.loadN = loadN_reg;
   assign bus.rwRead = rwRead_reg;
   assign bus.syncAddressIn = addr_reg;
   assign bus.byteWriteMaskN = mask_reg;
   assign bus.hostDq = hostDq_reg;
   assign bus.hostOe = hostOe_reg;
   assign rdValid = rdValid_reg;
   assign rdData = rdData_reg;

endmodule
`default_nettype wire

// [tb/dbsp_monitor.sv]
// Concurrent checks on the link pins between controller and SRAM device.
// Assumes it sits beside the link interface; samples on input clock rises.
`default_nettype none
module dbsp_monitor (
   input wire logic kClk,
   input wire logic cClk,
   input wire logic loadN,
   input wire logic rwRead,
   input wire logic [dbsp_pkg::ADDR_W-1:0] syncAddressIn,
   input wire logic [dbsp_pkg::LANES-1:0] byteWriteMaskN,
   input wire logic [dbsp_pkg::DATA_W-1:0] hostDq,
   input wire logic hostOe,
   input wire logic [dbsp_pkg::DATA_W-1:0] devDq,
   input wire logic devOe,
   input wire logic echoStrobeOut,
   input wire logic [dbsp_pkg::DATA_W-1:0] dq,
   input wire logic srst
);
   import dbsp_pkg::*;
   // ========================================
   // Command decode
   wire logic readCmd; // Load low, read select high
   wire logic writeCmd; // Load low, read select low
   assign readCmd = !loadN && rwRead;
   assign writeCmd = !loadN && !rwRead;
   // Device reset is the raw pin; sync lag only keeps outputs quiet longer
   default clocking linkCb @(posedge kClk);
   endclocking
   default disable iff (srst);
   // ========================================
   // Read pipeline
   a_read_first_drive:
   assert property (readCmd |-> ##2 devOe) else $error("read burst not driven");
   a_deselect_float:
   assert property (readCmd ##1 loadN |-> ##1 devOe ##1 !devOe)
      else $error("bus not released after deselect");
   a_write_no_drive:
   assert property (writeCmd |-> ##2 !devOe) else $error("device drove after write");
   a_idle_no_drive:
   assert property (loadN |-> ##2 !devOe) else $error("device drove while deselected");
   // ========================================
   // Late write beats from the controller
   a_write_beat_drive:
   assert property (writeCmd |-> ##1 (hostOe && !devOe))
      else $error("write beat not on bus");
   a_write_release:
   assert property (writeCmd ##1 !writeCmd |-> ##1 !hostOe)
      else $error("write data held too long");
   a_mask_idle:
   assert property (!hostOe |-> &byteWriteMaskN) else $error("mask active without data");
   a_no_contention:
   assert property (!(hostOe && devOe)) else $error("both ends drive the bus");
   cover property (readCmd ##1 loadN);
endmodule
`default_nettype wire

// [tb/test_ddr_burst2_sram_port.sv]
// Self-checking bench: controller and SRAM device on one link, a table
// of bursts, then calibration, loop-disable and reset cases.
// Assumes package, interface and both ends are compiled first.
`default_nettype none
module test_ddr_burst2_sram_port;
   timeunit 1ns;
   timeprecision 1ps;
   import dbsp_pkg::*;
   // ========================================
   // Rows: command fields beside the word a read should return
   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wd;
      logic [WLANES-1:0] maskN;
      logic [WORD_W-1:0] exp;
   } dbsp_row_s;
   localparam int CAL_PER = 8; // Short evaluation period keeps the run brief
   localparam int NROWS = 11;
   localparam dbsp_row_s ROWS [NROWS] = '{
      '{1'b0, 8'h10, {9'h104, 9'h103, 9'h102, 9'h101}, 4'h0, 36'h0},
      '{1'b0, 8'h13, {9'h1d4, 9'h1c3, 9'h1b2, 9'h0a1}, 4'h0, 36'h0},
      '{1'b1, 8'h10, 36'h0, 4'hf, {9'h104, 9'h103, 9'h102, 9'h101}},
      '{1'b1, 8'h13, 36'h0, 4'hf, {9'h1d4, 9'h1c3, 9'h1b2, 9'h0a1}},
      '{1'b1, 8'h12, 36'h0, 4'hf, {9'h1b2, 9'h0a1, 9'h1d4, 9'h1c3}},
      '{1'b0, 8'h10, {9'h1ff, 9'h1fe, 9'h1fd, 9'h1fc}, 4'h6, 36'h0},
      '{1'b0, 8'h13, {9'h0ee, 9'h0dd, 9'h0cc, 9'h0bb}, 4'hf, 36'h0},
      '{1'b1, 8'h10, 36'h0, 4'hf, {9'h1ff, 9'h103, 9'h102, 9'h1fc}},
      '{1'b0, 8'h11, {9'h111, 9'h122, 9'h133, 9'h144}, 4'h9, 36'h0},
      '{1'b1, 8'h12, 36'h0, 4'hf, {9'h1b2, 9'h0a1, 9'h1d4, 9'h1c3}},
      '{1'b1, 8'h10, 36'h0, 4'hf, {9'h133, 9'h103, 9'h102, 9'h122}}
   };
   logic clk;
   logic srst;
   logic devSrst; // Held longer: the device resets only while the link clock runs
   logic cmdValid, cmdRead, cmdReady, rdValid;
   logic [ADDR_W-1:0] cmdAddr;
   logic [WORD_W-1:0] cmdWrData, rdData;
   logic [WLANES-1:0] cmdWrMaskN;
   logic refAtSupply, impRaise, impLower, dllOffN, dllEnabled;
   logic outTie; // Output clock strap, moved only while no read is in flight
   logic [ZQ_CODE_W-1:0] impedanceCode;
   logic [WORD_W-1:0] expQ [$]; // Read words still owed, oldest first
   int errors, samples_checked, n, i;
   // ========================================
   // Design, both ends on one link
   dbsp_if link();
   dbsp_host dbsp_host_i (.clk(clk), .srst(srst), .bus(link), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
      .cmdWrMaskN(cmdWrMaskN), .rdValid(rdValid), .rdData(rdData));
   // Output clocks in use: host read taps assume that mode
   dbsp_device #(.ZQ_PERIOD(CAL_PER)) dbsp_device_i (.bus(link), .srst(devSrst),
      .cTiedHigh(outTie), .impedanceRefPinAtVddq(refAtSupply), .impedanceRaise(impRaise),
      .impedanceLower(impLower), .dllOffN(dllOffN), .impedanceCode(impedanceCode),
      .dllEnabled(dllEnabled));
   dbsp_monitor dbsp_monitor_i (.kClk(link.kClk), .cClk(link.cClk), .loadN(link.loadN),
      .rwRead(link.rwRead), .syncAddressIn(link.syncAddressIn),
      .byteWriteMaskN(link.byteWriteMaskN), .hostDq(link.hostDq), .hostOe(link.hostOe),
      .devDq(link.devDq), .devOe(link.devOe), .echoStrobeOut(link.echoStrobeOut),
      .dq(link.dq), .srst(devSrst));
   always #4 clk = ~clk;
   // ========================================
   // Shared tasks
   task automatic check(input string what, input logic [WORD_W-1:0] seen,
      input logic [WORD_W-1:0] want);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks made %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Holds the request until the edge that takes it
   task automatic issue(input dbsp_row_s r);
      int k;
      k = 0;
      cmdValid <= 1'b1;
      cmdRead <= r.rd;
      cmdAddr <= r.addr;
      cmdWrData <= r.wd;
      cmdWrMaskN <= r.maskN;
      do begin
         @(posedge clk);
         k++;
      end while (cmdReady !== 1'b1 && k < 20);
      check("command taken", 36'(k < 20), 36'h1);
      if (r.rd) begin
         expQ.push_back(r.exp);
      end
   endtask
   task automatic drain();
      int k;
      k = 0;
      cmdValid <= 1'b0;
      while (expQ.size() > 0 && k < 100) begin
         @(posedge clk);
         k++;
      end
      check("reads returned", 36'(expQ.size()), 36'h0);
   endtask
   // Counts clocks until the calibration code moves
   task automatic wait_code(output int k);
      logic [ZQ_CODE_W-1:0] old;
      old = impedanceCode;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (impedanceCode === old && k < 200);
   endtask
   task automatic wait_dll(input logic want);
      int k;
      k = 0;
      while (dllEnabled !== want && k < 40) begin
         @(posedge clk);
         k++;
      end
      check("loop enable", 36'(dllEnabled), 36'(want));
   endtask
   // Echo strobe must follow the clock that fires the outputs
   task automatic check_echo(input logic tie);
      logic want;
      repeat (4) begin
         @(negedge clk);
         want = tie ? link.kClk : link.cClk;
         check("echo strobe", 36'(link.echoStrobeOut), 36'(want));
      end
   endtask
   // Each returned burst against the oldest owed word
   always @(negedge clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() > 0) begin
            check("read word", rdData, expQ.pop_front());
         end else begin
            check("spare read", 36'h1, 36'h0);
         end
      end
   end
   // Watchdog, far beyond the few hundred clocks the tests need
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("watchdog expired");
      complete_run();
   end
   // ========================================
   // Main sequence
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      devSrst = 1'b1;
      cmdValid = 1'b0;
      cmdRead = 1'b0;
      cmdAddr = '0;
      cmdWrData = '0;
      cmdWrMaskN = '1;
      refAtSupply = 1'b0;
      impRaise = 1'b0;
      impLower = 1'b0;
      dllOffN = 1'b1;
      outTie = 1'b0;
      errors = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (24) @(posedge clk);
      devSrst <= 1'b0;
      repeat (24) @(posedge clk);
      check("code at start", 36'(impedanceCode), 36'(ZQ_CODE_RESET));
      for (i = 0; i < NROWS; i++) begin
         issue(ROWS[i]);
      end
      drain();
      $display("test table done");
      impRaise <= 1'b1;
      wait_code(n);
      check("step up", 36'(impedanceCode), 36'h21);
      wait_code(n);
      check("evaluation period", 36'(n), 36'(4 * CAL_PER));
      impRaise <= 1'b0;
      impLower <= 1'b1;
      wait_code(n);
      check("step down", 36'(impedanceCode), 36'h21);
      impLower <= 1'b0;
      refAtSupply <= 1'b1;
      wait_code(n);
      check("minimum impedance", 36'(impedanceCode), 36'(ZQ_CODE_MIN_Z));
      refAtSupply <= 1'b0;
      $display("test calibration done");
      dllOffN <= 1'b0;
      wait_dll(1'b0);
      dllOffN <= 1'b1;
      wait_dll(1'b1);
      $display("test loop disable done");
      // Strap moves with the bus idle; host reads are only valid untied
      check_echo(1'b0);
      @(posedge clk);
      outTie <= 1'b1;
      repeat (24) @(posedge clk);
      check_echo(1'b1);
      @(posedge clk);
      outTie <= 1'b0;
      $display("test output clock done");
      devSrst <= 1'b1;
      repeat (24) @(posedge clk);
      check("code after reset", 36'(impedanceCode), 36'(ZQ_CODE_RESET));
      check("device bus off", 36'(link.devOe), 36'h0);
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      check("ready in reset", 36'(cmdReady), 36'h0);
      check("load idle", 36'(link.loadN), 36'h1);
      check("masks idle", 36'(link.byteWriteMaskN), 36'h3);
      srst <= 1'b0;
      devSrst <= 1'b0;
      repeat (24) @(posedge clk);
      // Array survives reset
      issue(ROWS[NROWS-1]);
      drain();
      $display("test reset done");
      complete_run();
   end
endmodule
`default_nettype wire
